// [rtl/afc_bank.sv]
// Purpose: Advanced function configuration register bank.
// Assumes: Serial engine and main control register share this clock.
// Notes: Reads answer one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module afc_bank
  import afc_pkg::*;
#(
  parameter int TICK_CYCLES = AFC_WINDOW_LSB_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [7:0] reg_addr_next_out,
  input wire logic [7:0] main_ctrl_in,
  input wire logic main_ctrl_wr_in,
  output logic bank_mapped_out,
  output logic step_enable_out,
  output logic hub_enable_out,
  output logic highpass_output_select_out,
  output logic spi_wire_count_select_out,
  output logic i2c_disable_out,
  output logic addr_increment_out,
  output logic soft_reset_done_out,
  output logic boot_done_out,
  input wire logic slave_read_in,
  output logic [7:0] hub_write_byte_out,
  output logic hub_write_op_out,
  input wire logic location_change_in,
  input wire logic step_pulse_in,
  output logic sig_motion_irq_out,
  output logic step_recognized_out
);
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] wbyte_reg, wbyte_next;
  logic [7:0] thresh_reg, thresh_next;
  logic [7:0] window_reg, window_next;
  logic enable_reg, enable_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] anext_reg, anext_next;
  logic srst_prev_reg, srst_prev_next;
  logic boot_prev_reg, boot_prev_next;
  logic srst_done_reg, srst_done_next;
  logic boot_done_reg, boot_done_next;
  logic [7:0] ctrl_view;
  logic wr_hit;
  logic srst_rise;
  logic boot_rise;

  always_comb begin
    ctrl_view = main_ctrl_in;
    ctrl_view[AFC_BIT_RESERVED] = 1'b0;
    ctrl_view[AFC_BIT_ENABLE] = enable_reg;
  end

  assign wr_hit = reg_wr_in && enable_reg;
  assign srst_rise = main_ctrl_in[AFC_BIT_SOFT_RESET] && !srst_prev_reg;
  assign boot_rise = main_ctrl_in[AFC_BIT_BOOT] && !boot_prev_reg;

  always_comb begin
    wbyte_next = wbyte_reg;
    thresh_next = thresh_reg;
    window_next = window_reg;
    enable_next = enable_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    anext_next = anext_reg;
    srst_prev_next = main_ctrl_in[AFC_BIT_SOFT_RESET];
    boot_prev_next = main_ctrl_in[AFC_BIT_BOOT];
    srst_done_next = 1'b0;
    boot_done_next = 1'b0;
    if (main_ctrl_wr_in) begin
      enable_next = main_ctrl_in[AFC_BIT_ENABLE];
    end
    if (wr_hit) begin
      case (reg_addr_in)
        AFC_ADDR_WRITE_BYTE: begin
          wbyte_next = reg_wdata_in;
        end
        AFC_ADDR_THRESHOLD: begin
          thresh_next = reg_wdata_in;
        end
        AFC_ADDR_WINDOW: begin
          window_next = reg_wdata_in;
        end
        AFC_ADDR_CONTROL: begin
          enable_next = reg_wdata_in[AFC_BIT_ENABLE];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_in) begin
      rvalid_next = 1'b1;
      rdata_next = 8'h00;
      if (enable_reg) begin
        case (reg_addr_in)
          AFC_ADDR_WRITE_BYTE: begin
            rdata_next = wbyte_reg;
          end
          AFC_ADDR_THRESHOLD: begin
            rdata_next = thresh_reg;
          end
          AFC_ADDR_WINDOW: begin
            rdata_next = window_reg;
          end
          AFC_ADDR_CONTROL: begin
            rdata_next = ctrl_view;
          end
          default: begin
            rdata_next = 8'h00;
          end
        endcase
      end
    end
    if (reg_rd_in || reg_wr_in) begin
      if (main_ctrl_in[AFC_BIT_ADDR_INC]) begin
        anext_next = reg_addr_in + AFC_ADDR_STEP;
      end else begin
        anext_next = reg_addr_in;
      end
    end
    // reboot reloads defaults
    // Factory values are fixed images here, so a reboot cannot fail midway.
    if (boot_rise) begin
      wbyte_next = AFC_RST_WRITE_BYTE;
      thresh_next = AFC_RST_THRESHOLD;
      window_next = AFC_RST_WINDOW;
      boot_done_next = 1'b1;
    end
    if (main_ctrl_in[AFC_BIT_SOFT_RESET]) begin
      wbyte_next = AFC_RST_WRITE_BYTE;
      thresh_next = AFC_RST_THRESHOLD;
      window_next = AFC_RST_WINDOW;
      enable_next = AFC_RST_ENABLE;
      srst_done_next = srst_rise;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wbyte_reg <= AFC_RST_WRITE_BYTE;
      thresh_reg <= AFC_RST_THRESHOLD;
      window_reg <= AFC_RST_WINDOW;
      enable_reg <= AFC_RST_ENABLE;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      anext_reg <= 8'h00;
      srst_prev_reg <= 1'b0;
      boot_prev_reg <= 1'b0;
      srst_done_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end else if (ce_in) begin
      wbyte_reg <= wbyte_next;
      thresh_reg <= thresh_next;
      window_reg <= window_next;
      enable_reg <= enable_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      anext_reg <= anext_next;
      srst_prev_reg <= srst_prev_next;
      boot_prev_reg <= boot_prev_next;
      srst_done_reg <= srst_done_next;
      boot_done_reg <= boot_done_next;
    end
  end

  // ----------------------------------------------------------------------
  // Significant motion tracker
  // ----------------------------------------------------------------------
  afc_sm_state_t sm_reg, sm_next;
  logic [7:0] steps_reg, steps_next;
  logic irq_reg, irq_next;
  logic [8:0] steps_inc;

  assign steps_inc = {1'b0, steps_reg} + 9'h001;

  always_comb begin
    sm_next = sm_reg;
    steps_next = steps_reg;
    irq_next = 1'b0;
    if (!enable_reg) begin
      sm_next = AFC_SM_IDLE;
      steps_next = 8'h00;
    end else if (location_change_in) begin
      sm_next = AFC_SM_COUNT;
      steps_next = 8'h00;
    end else begin
      case (sm_reg)
        AFC_SM_IDLE: begin
        end
        AFC_SM_COUNT: begin
          if (step_pulse_in) begin
            steps_next = steps_inc[7:0];
            if (steps_inc >= {1'b0, thresh_reg}) begin
              irq_next = 1'b1;
              sm_next = AFC_SM_FIRED;
            end
          end
        end
        AFC_SM_FIRED: begin
        end
        default: begin
          sm_next = AFC_SM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sm_reg <= AFC_SM_IDLE;
      steps_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else if (ce_in) begin
      sm_reg <= sm_next;
      steps_reg <= steps_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------------
  // Step window and outputs
  // ----------------------------------------------------------------------
  afc_step_window #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_window (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .enable_in(enable_reg),
    .window_len_in(window_reg),
    .step_in(step_pulse_in),
    .step_recognized_out(step_recognized_out)
  );

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign reg_addr_next_out = anext_reg;
  assign bank_mapped_out = enable_reg;
  assign step_enable_out = enable_reg;
  assign hub_enable_out = enable_reg;
  assign highpass_output_select_out = main_ctrl_in[AFC_BIT_HIGHPASS];
  assign spi_wire_count_select_out = main_ctrl_in[AFC_BIT_SPI_WIRE];
  assign i2c_disable_out = main_ctrl_in[AFC_BIT_I2C_DISABLE];
  assign addr_increment_out = main_ctrl_in[AFC_BIT_ADDR_INC];
  assign soft_reset_done_out = srst_done_reg;
  assign boot_done_out = boot_done_reg;
  assign hub_write_byte_out = wbyte_reg;
  assign hub_write_op_out = enable_reg && !slave_read_in;
  assign sig_motion_irq_out = irq_reg;
endmodule
`default_nettype wire

// [rtl/afc_pkg.sv]
// Purpose: Shared constants for the advanced function configuration bank.
// Assumes: 250 MHz system clock; 8-bit internal register port.
// Notes: Offsets are the byte addresses on the internal register port.
package afc_pkg;
  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] AFC_ADDR_WRITE_BYTE = 8'h33;
  localparam logic [7:0] AFC_ADDR_THRESHOLD = 8'h34;
  localparam logic [7:0] AFC_ADDR_WINDOW = 8'h3a;
  localparam logic [7:0] AFC_ADDR_CONTROL = 8'h3f;
  localparam logic [7:0] AFC_RST_WRITE_BYTE = 8'h00;
  localparam logic [7:0] AFC_RST_THRESHOLD = 8'h06;
  localparam logic [7:0] AFC_RST_WINDOW = 8'h00;
  localparam logic AFC_RST_ENABLE = 1'b1;
  localparam logic [7:0] AFC_ADDR_STEP = 8'h01;
  // ----------------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------------
  localparam int AFC_BIT_BOOT = 7;
  localparam int AFC_BIT_SOFT_RESET = 6;
  localparam int AFC_BIT_RESERVED = 5;
  localparam int AFC_BIT_ENABLE = 4;
  localparam int AFC_BIT_HIGHPASS = 3;
  localparam int AFC_BIT_ADDR_INC = 2;
  localparam int AFC_BIT_I2C_DISABLE = 1;
  localparam int AFC_BIT_SPI_WIRE = 0;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int AFC_CLK_MHZ = 250;
  localparam int AFC_WINDOW_LSB_US = 1638400;
  localparam int AFC_WINDOW_LSB_CYCLES = AFC_WINDOW_LSB_US * AFC_CLK_MHZ;
  // ----------------------------------------------------------------------
  // Significant motion tracker states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    AFC_SM_IDLE = 2'b00,
    AFC_SM_COUNT = 2'b01,
    AFC_SM_FIRED = 2'b11
  } afc_sm_state_t;
endpackage

// [rtl/afc_step_window.sv]
// Purpose: Step recognition window timer.
// Assumes: Step pulses come from logic on the same clock.
// Notes: A window length of zero accepts every step while enabled.
`timescale 1ns/1ps
`default_nettype none
module afc_step_window
  import afc_pkg::*;
#(
  parameter int TICK_CYCLES = AFC_WINDOW_LSB_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic enable_in,
  input wire logic [7:0] window_len_in,
  input wire logic step_in,
  output logic step_recognized_out
);
  // ----------------------------------------------------------------------
  // Window counting
  // ----------------------------------------------------------------------
  logic [31:0] tick_reg, tick_next;
  logic [7:0] left_reg, left_next;
  logic recog_reg, recog_next;

  always_comb begin
    tick_next = tick_reg;
    left_next = left_reg;
    recog_next = 1'b0;
    if (!enable_in) begin
      tick_next = 32'h0000_0000;
      left_next = window_len_in;
    end else if (step_in) begin
      // A step restarts the window, so steady walking is never cut off.
      recog_next = (window_len_in == 8'h00) || (left_reg != 8'h00);
      tick_next = 32'h0000_0000;
      left_next = window_len_in;
    end else if (left_reg != 8'h00) begin
      if (tick_reg >= 32'(TICK_CYCLES - 1)) begin
        tick_next = 32'h0000_0000;
        left_next = left_reg - 8'h01;
      end else begin
        tick_next = tick_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_reg <= 32'h0000_0000;
      left_reg <= 8'h00;
      recog_reg <= 1'b0;
    end else if (ce_in) begin
      tick_reg <= tick_next;
      left_reg <= left_next;
      recog_reg <= recog_next;
    end
  end

  assign step_recognized_out = recog_reg;
endmodule
`default_nettype wire

// [verif/afc_bank_sva.sv]
// Purpose: Port checks for afc_bank.
// Assumes: One clock, reset active low.
// Notes: Bound to every afc_bank instance.
`timescale 1ns/1ps
`default_nettype none
module afc_bank_sva
  import afc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] reg_addr_next_out,
  input wire logic [7:0] main_ctrl_in,
  input wire logic main_ctrl_wr_in,
  input wire logic bank_mapped_out,
  input wire logic step_enable_out,
  input wire logic hub_enable_out,
  input wire logic highpass_output_select_out,
  input wire logic spi_wire_count_select_out,
  input wire logic i2c_disable_out,
  input wire logic addr_increment_out,
  input wire logic soft_reset_done_out,
  input wire logic boot_done_out,
  input wire logic slave_read_in,
  input wire logic [7:0] hub_write_byte_out,
  input wire logic hub_write_op_out,
  input wire logic sig_motion_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_unmapped_read_zero: assert property (
    ce_in && reg_rd_in && !bank_mapped_out |=> reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_control_read_mirror: assert property (
    ce_in && reg_rd_in && bank_mapped_out && reg_addr_in == AFC_ADDR_CONTROL
    |=> reg_rdata_out == {$past(main_ctrl_in[7:6]), 1'b0, 1'b1, $past(main_ctrl_in[3:0])})
    else $error("control read wrong");
  a_addr_next_step: assert property (
    ce_in && (reg_rd_in || reg_wr_in) && bank_mapped_out
    |=> reg_addr_next_out == $past(reg_addr_in) + {7'h00, $past(main_ctrl_in[2])})
    else $error("next address wrong");
  a_disable_unmaps: assert property (
    ce_in && reg_wr_in && bank_mapped_out && reg_addr_in == AFC_ADDR_CONTROL
    && !reg_wdata_in[4] && !main_ctrl_in[6] && !main_ctrl_wr_in
    |=> !bank_mapped_out && !step_enable_out && !hub_enable_out)
    else $error("bank still mapped");
  a_write_byte_load: assert property (
    ce_in && reg_wr_in && bank_mapped_out && reg_addr_in == AFC_ADDR_WRITE_BYTE
    && main_ctrl_in[7:6] == 2'b00 |=> hub_write_byte_out == $past(reg_wdata_in))
    else $error("write byte not loaded");
  a_mirror_copies: assert property (
    highpass_output_select_out == main_ctrl_in[3] && addr_increment_out == main_ctrl_in[2]
    && spi_wire_count_select_out == main_ctrl_in[0] && i2c_disable_out == main_ctrl_in[1])
    else $error("mirror bit differs");
  a_hub_direction: assert property (
    hub_write_op_out == (bank_mapped_out && !slave_read_in)) else $error("hub direction wrong");
  a_soft_reset_done: assert property (
    ce_in && $rose(main_ctrl_in[6]) |=> soft_reset_done_out) else $error("no soft reset done");
  a_soft_reset_restore: assert property (
    ce_in && main_ctrl_in[6] |=> bank_mapped_out && hub_write_byte_out == 8'h00)
    else $error("soft reset not restored");
  a_boot_done: assert property (
    ce_in && $rose(main_ctrl_in[7]) |=> boot_done_out) else $error("no boot done");
  a_irq_single: assert property (
    sig_motion_irq_out |=> !sig_motion_irq_out) else $error("interrupt too long");
endmodule
bind afc_bank afc_bank_sva i_afc_bank_sva (.clk_sys_in, .rstn_in, .ce_in, .reg_addr_in,
  .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .reg_addr_next_out,
  .main_ctrl_in, .main_ctrl_wr_in, .bank_mapped_out, .step_enable_out, .hub_enable_out,
  .highpass_output_select_out, .spi_wire_count_select_out, .i2c_disable_out,
  .addr_increment_out, .soft_reset_done_out, .boot_done_out, .slave_read_in,
  .hub_write_byte_out, .hub_write_op_out, .sig_motion_irq_out);
`default_nettype wire

// [verif/afc_host_model.sv]
// Purpose: Host side of the register port.
// Assumes: Requests launch on the falling clock edge.
// Notes: Released lines show the inverse of the requested address and data.
`timescale 1ns/1ps
`default_nettype none
module afc_host_model
  import afc_pkg::*;
(
  input wire logic clk_sys_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    wdata_out = (a == AFC_ADDR_CONTROL) ? (d & 8'hdf) : d;
    wr_out = 1'b1;
    @(negedge clk_sys_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_sys_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_sys_in);
    d = rdata_in;
    v = rvalid_in;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule
`default_nettype wire

// [verif/test_advanced_function_config_bank.sv]
// Purpose: Self-checking bench for afc_bank.
// Assumes: Window tick shortened to four cycles.
// Notes: Inputs move on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_advanced_function_config_bank
  import afc_pkg::*;
;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, main_ctrl_wr_in = 1'b0;
  logic slave_read_in = 1'b0, location_change_in = 1'b0, step_pulse_in = 1'b0;
  logic [7:0] main_ctrl_in = 8'h00;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, reg_addr_next_out, hub_write_byte_out;
  logic reg_wr_in, reg_rd_in, reg_rvalid_out, bank_mapped_out, step_enable_out, hub_enable_out;
  logic highpass_output_select_out, spi_wire_count_select_out, i2c_disable_out;
  logic addr_increment_out, soft_reset_done_out, boot_done_out, hub_write_op_out;
  logic sig_motion_irq_out, step_recognized_out, v;
  logic [7:0] d, x;
  int failures = 0, num_checks = 0, cyc = 0, irqs = 0, recs = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  afc_bank #(.TICK_CYCLES(4)) i_dut (.clk_sys_in, .rstn_in, .ce_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .reg_addr_next_out,
    .main_ctrl_in, .main_ctrl_wr_in, .bank_mapped_out, .step_enable_out, .hub_enable_out,
    .highpass_output_select_out, .spi_wire_count_select_out, .i2c_disable_out,
    .addr_increment_out, .soft_reset_done_out, .boot_done_out, .slave_read_in,
    .hub_write_byte_out, .hub_write_op_out, .location_change_in, .step_pulse_in,
    .sig_motion_irq_out, .step_recognized_out);
  afc_host_model i_host (.clk_sys_in, .addr_out(reg_addr_in), .wr_out(reg_wr_in),
    .rd_out(reg_rd_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out));
  always @(posedge clk_sys_in) begin
    irqs += (sig_motion_irq_out === 1'b1);
    recs += (step_recognized_out === 1'b1);
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [7:0] ctrl_exp(input logic [7:0] m);
    return {m[7:6], 2'b01, m[3:0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys_in) s = 1'b1;
    @(negedge clk_sys_in) s = 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(22863));
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in) rstn_in = 1'b1;
    main_ctrl_in = {4'h0, 4'($urandom())};
    rchk(AFC_ADDR_WRITE_BYTE, 8'h00);
    rchk(AFC_ADDR_THRESHOLD, 8'h06);
    rchk(AFC_ADDR_WINDOW, 8'h00);
    check(step_enable_out & hub_enable_out, 1'b1);
    i_host.wr(AFC_ADDR_CONTROL, 8'hff);
    rchk(AFC_ADDR_CONTROL, ctrl_exp(main_ctrl_in));
    for (int i = 0; i < 6; i++) begin
      x = 8'($urandom());
      slave_read_in = i[0];
      main_ctrl_in[3:0] = {i[2], i[1], ~i[0], i[0]};
      i_host.wr(AFC_ADDR_WRITE_BYTE, x);
      check(hub_write_byte_out, x);
      check(hub_write_op_out, !slave_read_in);
      rchk(AFC_ADDR_WINDOW + 8'h01, 8'h00);
      i_host.wr(AFC_ADDR_WINDOW, ~x);
      rchk(AFC_ADDR_WINDOW, ~x);
      check(reg_addr_next_out, AFC_ADDR_WINDOW + main_ctrl_in[2]);
      check(highpass_output_select_out, main_ctrl_in[3]);
      check(spi_wire_count_select_out, main_ctrl_in[0]);
      check(i2c_disable_out, main_ctrl_in[1]);
      check(addr_increment_out, main_ctrl_in[2]);
      rchk(AFC_ADDR_CONTROL, ctrl_exp(main_ctrl_in));
    end
    i_host.wr(AFC_ADDR_THRESHOLD, 8'h03);
    irqs = 0;
    pulse(location_change_in);
    repeat (2) pulse(step_pulse_in);
    check(8'(irqs), 8'h00);
    pulse(step_pulse_in);
    repeat (2) @(negedge clk_sys_in);
    check(8'(irqs), 8'h01);
    pulse(step_pulse_in);
    repeat (2) @(negedge clk_sys_in);
    check(8'(irqs), 8'h01);
    i_host.wr(AFC_ADDR_WINDOW, 8'h00);
    recs = 0;
    pulse(step_pulse_in);
    repeat (2) @(negedge clk_sys_in);
    check(8'(recs), 8'h01);
    i_host.wr(AFC_ADDR_WINDOW, 8'h02);
    pulse(step_pulse_in);
    recs = 0;
    pulse(step_pulse_in);
    repeat (2) @(negedge clk_sys_in);
    check(8'(recs), 8'h01);
    repeat (30) @(negedge clk_sys_in);
    recs = 0;
    pulse(step_pulse_in);
    repeat (2) @(negedge clk_sys_in);
    check(8'(recs), 8'h00);
    main_ctrl_in[6] = 1'b1;
    @(negedge clk_sys_in) main_ctrl_in[6] = 1'b0;
    rchk(AFC_ADDR_THRESHOLD, 8'h06);
    rchk(AFC_ADDR_WINDOW, 8'h00);
    i_host.wr(AFC_ADDR_THRESHOLD, 8'h77);
    main_ctrl_in[7] = 1'b1;
    @(negedge clk_sys_in) main_ctrl_in[7] = 1'b0;
    rchk(AFC_ADDR_THRESHOLD, 8'h06);
    ce_in = 1'b0;
    i_host.wr(AFC_ADDR_WRITE_BYTE, 8'h99);
    ce_in = 1'b1;
    rchk(AFC_ADDR_WRITE_BYTE, 8'h00);
    i_host.wr(AFC_ADDR_CONTROL, 8'h00);
    check(bank_mapped_out, 1'b0);
    check(step_enable_out | hub_enable_out, 1'b0);
    i_host.wr(AFC_ADDR_THRESHOLD, 8'h22);
    rchk(AFC_ADDR_THRESHOLD, 8'h00);
    main_ctrl_in[4] = 1'b1;
    pulse(main_ctrl_wr_in);
    check(bank_mapped_out, 1'b1);
    rchk(AFC_ADDR_THRESHOLD, 8'h06);
    give_verdict();
  end
endmodule
`default_nettype wire
